// >>> logic/i2rs_pkg.sv
// Types shared by the I2C register slave and its users.
// Assumes a SystemVerilog tool; no constants beyond the types.
package i2rs_pkg;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_IDX  = 6'h04,
    ST_WR   = 6'h08,
    ST_RD   = 6'h10,
    ST_GC   = 6'h20
  } i2rs_state_t;
  typedef struct packed {
    logic        wide;
    logic [7:0]  addr;
    logic [15:0] data;
  } i2rs_wr_t;
endpackage

// >>> logic/i2rs_regs.svh
// Constants of the I2C register slave: addresses, command bytes, counts.
// Included by the slave module; holds definitions only.
`ifndef I2RS_REGS_SVH
`define I2RS_REGS_SVH
`define I2RS_DEF_SA     7'h45
`define I2RS_GC_ADDR    8'h00
`define I2RS_GC_RESET   8'h06
`define I2RS_GC_SEL     1
`define I2RS_MFR_IDX    8'h80
`define I2RS_VER_IDX    8'h81
`define I2RS_BITS       4'h8
`define I2RS_SA_WAIT    4'h8
`define I2RS_IDX_STEP   8'h01
`endif

// >>> logic/i2rs_slave.sv
// I2C slave front end: byte access to an internal register space.
// Assumes SCL/SDA arrive asynchronously and are sampled at 250 MHz;
// the register file answers i_rd_data for o_index combinationally.
// Operation
// - Answer default address after power-on.
// - Works at 100 and 400 kHz.
// - Respond to general call and own address.
// - Repeated START begins new addressed transfer.
// - Registers selected by 8-bit index.
// - Index auto-increments after each data byte.
// - Address reprogrammable only after enable pin seen high.
// - Address write waits eight cycles or pin.
// - Half-written wide register stays unchanged.
// - Matching address acknowledged low.
// - Write: index byte then acknowledged data.
// - Index increments per accepted write byte.
// - STOP restores index to burst start.
// - Read returns indexed register, then increments.
// - General call 0x06 pulses global reset.
// - General call select zero restores address.
// - General call enabled after identity reads.
`timescale 1ns/1ps
`default_nettype none
`include "i2rs_regs.svh"
module i2rs_slave (
  input  wire logic               i_core_clk,
  input  wire logic               i_rst_n,
  input  wire logic               i_scl,
  input  wire logic               i_sda,
  output var  logic               o_sda_out,
  output var  logic               o_sda_oe,
  input  wire logic               i_address_change_enable_pin,
  input  wire logic               i_sa_wr,
  input  wire logic [6:0]         i_sa_value,
  input  wire logic               i_wide,
  input  wire logic [7:0]         i_rd_data,
  output var  logic [7:0]         o_index,
  output var  logic               o_wr_stb,
  output var  i2rs_pkg::i2rs_wr_t o_wr,
  output var  logic               o_glob_rst,
  output var  logic [6:0]         o_slave_address_register
);
  import i2rs_pkg::*;

  // Pin synchronisers: bit 2 enable, bit 1 SCL, bit 0 SDA
  // Enable resets low: a reset-time high must not arm address change
  // 250 MHz sampling covers 400 kHz
  logic [2:0]  sync1;
  logic [2:0]  sync2;
  logic [1:0]  prev;
  logic [2:0]  next_sync1;
  logic [2:0]  next_sync2;
  logic [1:0]  next_prev;

  always_comb begin
    next_sync1 = {i_address_change_enable_pin, i_scl, i_sda};
    next_sync2 = sync1;
    next_prev  = sync2[1:0];
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1 <= 3'h3;
      sync2 <= 3'h3;
      prev  <= 2'h3;
    end else begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
      prev  <= next_prev;
    end
  end

  logic scl_s;
  logic sda_s;
  logic aen_s;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  assign scl_s    = sync2[1];
  assign sda_s    = sync2[0];
  assign aen_s    = sync2[2];
  assign scl_rise = scl_s && !prev[1];
  assign scl_fall = !scl_s && prev[1];
  assign start    = scl_s && prev[1] && prev[0] && !sda_s;
  assign stop     = scl_s && prev[1] && !prev[0] && sda_s;

  // Address-change gate: cycle count since reset and pin seen high
  logic [3:0] wait_cnt;
  logic       aen_seen;
  logic [3:0] next_wait_cnt;
  logic       next_aen_seen;
  logic       sa_accept;

  always_comb begin
    next_wait_cnt = wait_cnt;
    if (wait_cnt != `I2RS_SA_WAIT) next_wait_cnt = wait_cnt + 4'h1;
    next_aen_seen = aen_seen || aen_s;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wait_cnt <= 4'h0;
      aen_seen <= 1'b0;
    end else begin
      wait_cnt <= next_wait_cnt;
      aen_seen <= next_aen_seen;
    end
  end

  // pin tied low blocks any change
  // eight cycles, or at once with pin high
  assign sa_accept = i_sa_wr && aen_seen && (wait_cnt == `I2RS_SA_WAIT || aen_s);

  // Protocol engine
  i2rs_state_t state;
  i2rs_state_t next_state;
  logic [3:0]  bitcnt;
  logic [3:0]  next_bitcnt;
  logic [7:0]  shift;
  logic [7:0]  next_shift;
  logic [7:0]  tx;
  logic [7:0]  next_tx;
  logic [7:0]  base;
  logic [7:0]  next_base;
  logic [7:0]  lo;
  logic [7:0]  next_lo;
  logic        in_ack;
  logic        next_in_ack;
  logic        nack;
  logic        next_nack;
  logic        half;
  logic        next_half;
  logic        seen_mfr;
  logic        next_seen_mfr;
  logic        seen_ver;
  logic        next_seen_ver;
  logic        next_oe;
  logic [7:0]  next_index;
  logic        next_wr_stb;
  i2rs_wr_t    next_wr;
  logic        next_grst;
  logic [6:0]  next_sa;
  logic        byte_end;

  assign byte_end = scl_fall && !in_ack && bitcnt == `I2RS_BITS;

  always_comb begin
    next_state    = state;
    next_bitcnt   = bitcnt;
    next_shift    = shift;
    next_tx       = tx;
    next_base     = base;
    next_lo       = lo;
    next_in_ack   = in_ack;
    next_nack     = nack;
    next_half     = half;
    next_seen_mfr = seen_mfr;
    next_seen_ver = seen_ver;
    next_oe       = o_sda_oe;
    next_index    = o_index;
    next_wr_stb   = 1'b0;
    next_wr       = o_wr;
    next_grst     = 1'b0;
    next_sa       = o_slave_address_register;
    if (sa_accept) next_sa = i_sa_value;
    if (start) begin
      next_state  = ST_ADDR;
      next_bitcnt = 4'h0;
      next_in_ack = 1'b0;
      next_oe     = 1'b0;
      next_half   = 1'b0;
    end else if (stop) begin
      // stop ends read at any byte
      next_state  = ST_IDLE;
      next_index  = base;
      next_in_ack = 1'b0;
      next_oe     = 1'b0;
      next_half   = 1'b0;
    end else if (scl_rise) begin
      if (in_ack) begin
        next_nack = sda_s;
      end else begin
        next_shift  = {shift[6:0], sda_s};
        next_bitcnt = bitcnt + 4'h1;
      end
    end else if (scl_fall && in_ack) begin
      next_in_ack = 1'b0;
      next_bitcnt = 4'h0;
      next_oe     = 1'b0;
      if (state == ST_RD) begin
        if (nack) begin
          next_state = ST_IDLE;
        end else begin
          next_tx    = {i_rd_data[6:0], 1'b0};
          next_oe    = !i_rd_data[7];
          next_index = o_index + `I2RS_IDX_STEP;
          if (o_index == `I2RS_MFR_IDX) next_seen_mfr = 1'b1;
          if (o_index == `I2RS_VER_IDX) next_seen_ver = 1'b1;
        end
      end
    end else if (byte_end) begin
      next_in_ack = 1'b1;
      case (state)
        ST_ADDR: begin
          if (shift[7:1] == o_slave_address_register) begin
            next_oe    = 1'b1;
            next_nack  = 1'b0;
            next_state = shift[0] ? ST_RD : ST_IDX;
          end else if (shift == `I2RS_GC_ADDR && seen_mfr && seen_ver) begin
            next_oe    = 1'b1;
            next_state = ST_GC;
          end else begin
            next_in_ack = 1'b0;
            next_state  = ST_IDLE;
          end
        end
        ST_IDX: begin
          next_oe    = 1'b1;
          next_index = shift;
          next_base  = shift;
          next_half  = 1'b0;
          next_state = ST_WR;
        end
        ST_WR: begin
          next_oe = 1'b1;
          if (half) begin
            next_wr_stb  = 1'b1;
            next_wr.wide = 1'b1;
            next_wr.addr = o_index - `I2RS_IDX_STEP;
            next_wr.data = {shift, lo};
            next_half    = 1'b0;
          end else if (i_wide) begin
            next_lo   = shift;
            next_half = 1'b1;
          end else begin
            next_wr_stb  = 1'b1;
            next_wr.wide = 1'b0;
            next_wr.addr = o_index;
            next_wr.data = {8'h00, shift};
          end
          next_index = o_index + `I2RS_IDX_STEP;
        end
        ST_GC: begin
          next_oe    = 1'b1;
          next_state = ST_IDLE;
          if (shift == `I2RS_GC_RESET) next_grst = 1'b1;
          if (!shift[`I2RS_GC_SEL]) next_sa = `I2RS_DEF_SA;
        end
        ST_RD: next_oe = 1'b0;
        default: next_in_ack = 1'b0;
      endcase
    end else if (scl_fall && state == ST_RD && bitcnt != 4'h0) begin
      next_oe = !tx[7];
      next_tx = {tx[6:0], 1'b0};
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state    <= ST_IDLE;
      bitcnt   <= 4'h0;
      shift    <= 8'h00;
      tx       <= 8'h00;
      base     <= 8'h00;
      lo       <= 8'h00;
      in_ack   <= 1'b0;
      nack     <= 1'b0;
      half     <= 1'b0;
      seen_mfr <= 1'b0;
      seen_ver <= 1'b0;
      o_sda_oe <= 1'b0;
      o_index  <= 8'h00;
      o_wr_stb <= 1'b0;
      o_wr     <= '0;
      o_glob_rst <= 1'b0;
      o_slave_address_register <= `I2RS_DEF_SA;
    end else begin
      state    <= next_state;
      bitcnt   <= next_bitcnt;
      shift    <= next_shift;
      tx       <= next_tx;
      base     <= next_base;
      lo       <= next_lo;
      in_ack   <= next_in_ack;
      nack     <= next_nack;
      half     <= next_half;
      seen_mfr <= next_seen_mfr;
      seen_ver <= next_seen_ver;
      o_sda_oe <= next_oe;
      o_index  <= next_index;
      o_wr_stb <= next_wr_stb;
      o_wr     <= next_wr;
      o_glob_rst <= next_grst;
      o_slave_address_register <= next_sa;
    end
  end

  // Open drain: the pin is only ever pulled low
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) o_sda_out <= 1'b0;
    else          o_sda_out <= 1'b0;
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  sa_write_gate_a: assert property (
    $changed(o_slave_address_register) && o_slave_address_register != `I2RS_DEF_SA
      |-> $past(i_sa_wr) && $past(aen_seen))
    else $error("slave address changed without enabled write");
  sa_early_block_a: assert property (
    i_sa_wr && !aen_s && wait_cnt != `I2RS_SA_WAIT
      |=> o_slave_address_register == $past(o_slave_address_register)
          || o_slave_address_register == `I2RS_DEF_SA)
    else $error("slave address taken before wait ended");
  addr_ack_a: assert property (
    byte_end && state == ST_ADDR && shift[7:1] == o_slave_address_register
      |=> o_sda_oe && in_ack ##1 o_sda_oe)
    else $error("matching address not acknowledged");
  foreign_nack_a: assert property (
    byte_end && state == ST_ADDR && shift[7:1] != o_slave_address_register
      && shift != `I2RS_GC_ADDR |=> !o_sda_oe && state == ST_IDLE)
    else $error("foreign address acknowledged");
  index_load_a: assert property (
    byte_end && state == ST_IDX |=> o_index == $past(shift) && state == ST_WR)
    else $error("index byte not loaded");
  stop_index_a: assert property (
    stop |=> o_index == $past(base) && state == ST_IDLE)
    else $error("stop did not restore index");
  read_step_a: assert property (
    scl_fall && in_ack && state == ST_RD && !nack && !start && !stop
      |=> o_index == $past(o_index) + `I2RS_IDX_STEP)
    else $error("read did not advance index");
  gc_reset_a: assert property (
    byte_end && state == ST_GC && shift == `I2RS_GC_RESET && !start && !stop
      |=> o_glob_rst ##1 !o_glob_rst)
    else $error("general call reset not pulsed once");
  restart_a: assert property (
    start |=> state == ST_ADDR && bitcnt == 4'h0 && !o_sda_oe)
    else $error("start did not reopen address phase");
  wide_drop_a: assert property (
    stop && half |=> !o_wr_stb && !half)
    else $error("half wide write leaked");
endmodule // i2rs_slave
`default_nettype wire

// >>> tb/i2c_register_slave_test.sv
// Self-checking bench for the register slave behind a modelled bus master.
// Register file stand-in: read data is index xor 5A, index 20 is wide.
`timescale 1ns/1ps
`default_nettype none
module i2c_register_slave_test;
  import i2rs_pkg::*;
  logic       clk, rst_n, pin, sa_wr, ack;
  logic [6:0] sa_val;
  logic [15:0] q;
  wire logic  scl, m_oe, sda_oe, sda_out, wr_stb, glob_rst;
  wire logic [7:0] index;
  wire logic [6:0] sa;
  wire i2rs_wr_t wr;
  wire logic  sda = ~(m_oe | sda_oe);
  int         n_errors = 0, checks = 0, n_glob = 0;
  i2rs_wr_t   wq[$];
  i2rs_slave u_dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda),
    .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_address_change_enable_pin(pin),
    .i_sa_wr(sa_wr), .i_sa_value(sa_val), .i_wide(index == 8'h20),
    .i_rd_data(index ^ 8'h5A), .o_index(index), .o_wr_stb(wr_stb), .o_wr(wr),
    .o_glob_rst(glob_rst), .o_slave_address_register(sa));
  i2rs_master_model u_mst (.i_sda(sda), .o_scl(scl), .o_sda_oe(m_oe));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    if (wr_stb === 1'b1) wq.push_back(wr);
    if (glob_rst === 1'b1) n_glob++;
  end
  task automatic check(input logic [24:0] g, input logic [24:0] e);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_wr(input logic [24:0] e);
    logic [24:0] g;
    g = 'x;
    if (wq.size() > 0) g = wq.pop_front();
    check(g, e);
  endtask
  task automatic set_sa(input logic [6:0] v);
    @(posedge clk) #1 sa_wr = 1'b1;
    sa_val = v;
    @(posedge clk) #1 sa_wr = 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic wr_burst(input logic [6:0] a, input logic [7:0] idx, input int n,
                          input logic [15:0] d);
    u_mst.start_c();
    u_mst.send({a, 1'b0}, ack);
    check(ack, 1'b0);
    u_mst.send(idx, ack);
    check(ack, 1'b0);
    for (int i = 0; i < n; i++) begin
      u_mst.send(d[8*i+:8], ack);
      check(ack, 1'b0);
    end
    u_mst.stop_c();
  endtask
  task automatic rd_burst(input logic [6:0] a, input logic [7:0] idx);
    u_mst.start_c();
    u_mst.send({a, 1'b0}, ack);
    u_mst.send(idx, ack);
    check(ack, 1'b0);
    u_mst.start_c();
    u_mst.send({a, 1'b1}, ack);
    check(ack, 1'b0);
    u_mst.recv(1'b0, q[15:8]);
    u_mst.recv(1'b1, q[7:0]);
    u_mst.stop_c();
  endtask
  task automatic gcall(input logic [7:0] b, input logic e);
    u_mst.start_c();
    u_mst.send(8'h00, ack);
    check(ack, e);
    if (ack === 1'b0) u_mst.send(b, ack);
    u_mst.stop_c();
  endtask
  task automatic wrap_up();
    $display("n_errors=%0d checks=%0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #300000;
    n_errors++;
    wrap_up();
  end
  initial begin
    rst_n = 1'b0;
    pin = 1'b0;
    sa_wr = 1'b0;
    sa_val = 7'h00;
    repeat (8) @(posedge clk);
    #1 rst_n = 1'b1;
    check(sa, 7'h45);
    check(index, 8'h00);
    check(sda_out, 1'b0);
    set_sa(7'h33);
    check(sa, 7'h45);
    gcall(8'h06, 1'b1);
    u_mst.start_c();
    u_mst.send({7'h46, 1'b0}, ack);
    check(ack, 1'b1);
    u_mst.stop_c();
    wr_burst(7'h45, 8'h10, 2, 16'h3CA5);
    chk_wr({1'b0, 8'h10, 16'h00A5});
    chk_wr({1'b0, 8'h11, 16'h003C});
    check(index, 8'h10);
    wr_burst(7'h45, 8'h20, 1, 16'h0011);
    check(wq.size(), 0);
    wr_burst(7'h45, 8'h20, 2, 16'h2211);
    chk_wr({1'b1, 8'h20, 16'h2211});
    rd_burst(7'h45, 8'h80);
    check(q, 16'hDADB);
    check(index, 8'h80);
    @(posedge clk) #1 pin = 1'b1;
    repeat (4) @(posedge clk);
    set_sa(7'h33);
    check(sa, 7'h33);
    wr_burst(7'h33, 8'h30, 1, 16'h0077);
    chk_wr({1'b0, 8'h30, 16'h0077});
    gcall(8'h06, 1'b0);
    check(n_glob, 1);
    check(sa, 7'h33);
    gcall(8'h04, 1'b0);
    check(sa, 7'h45);
    wrap_up();
  end
endmodule // i2c_register_slave_test
`default_nettype wire

// >>> tb/i2rs_master_model.sv
// Bus master model: drives the clock line and pulls the data line low.
// Assumes the bench resolves the pulled-up data line from all enables.
`timescale 1ns/1ps
`default_nettype none
module i2rs_master_model (
  input  wire logic i_sda,
  output var  logic o_scl,
  output var  logic o_sda_oe
);
  // 160 ns bus clock; the 20 ns hold keeps data edges clear of clock falls
  initial begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
  end
  task automatic start_c();
    #20 o_sda_oe = 1'b0;
    #40 o_scl = 1'b1;
    #40 o_sda_oe = 1'b1;
    #80 o_scl = 1'b0;
  endtask
  task automatic stop_c();
    #20 o_sda_oe = 1'b1;
    #40 o_scl = 1'b1;
    #40 o_sda_oe = 1'b0;
    #80;
  endtask
  // bytes go out MSB first, ack read on ninth clock
  task automatic send(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #40 o_sda_oe = ~b[i];
      #40 o_scl = 1'b1;
      #80 o_scl = 1'b0;
    end
    #20 o_sda_oe = 1'b0;
    #60 o_scl = 1'b1;
    #40 ack = i_sda;
    #40 o_scl = 1'b0;
  endtask
  task automatic recv(input logic nack, output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      #20 o_sda_oe = 1'b0;
      #60 o_scl = 1'b1;
      #40 b[i] = i_sda;
      #40 o_scl = 1'b0;
    end
    #40 o_sda_oe = ~nack;
    #40 o_scl = 1'b1;
    #80 o_scl = 1'b0;
  endtask
endmodule // i2rs_master_model
`default_nettype wire
